// ===== src/pmcr_pkg.sv
package pmcr_pkg;
	// clock and time figures
	localparam int CLK_HZ         = 40_000_000;
	localparam int CYC_PER_MS     = CLK_HZ / 1000;
	localparam int QUIET_MIN_MS   = 1200;
	localparam int QUIET_MAX_MS   = 1500;
	localparam int QUIET_CYC      = QUIET_MIN_MS * CYC_PER_MS;
	localparam int PHY_RST_MS     = 50;
	localparam int PHY_RST_CYC    = PHY_RST_MS * CYC_PER_MS;
	localparam int PDN_READY_MS   = 500;
	localparam int PDN_READY_CYC  = PDN_READY_MS * CYC_PER_MS;
	localparam int JABBER_MS      = 20;
	localparam int JABBER_CYC     = JABBER_MS * CYC_PER_MS;
	localparam int PIN_RST_NS     = 100;
	localparam int CLK_PERIOD_NS  = 25;
	localparam int PIN_RST_CYC    = (PIN_RST_NS + CLK_PERIOD_NS - 1)
	                                / CLK_PERIOD_NS;
	localparam int POL_BAD_PULSES = 3;

	// register byte offsets
	localparam logic [7:0] OFS_MAC_CTRL  = 8'h00;
	localparam logic [7:0] OFS_PHY_CTRL  = 8'h04;
	localparam logic [7:0] OFS_PHY_CFG   = 8'h08;
	localparam logic [7:0] OFS_PHY_STAT  = 8'h0C;
	localparam logic [7:0] OFS_PHY_SOUT  = 8'h10;
	localparam logic [7:0] OFS_PHY_MASK  = 8'h14;
	localparam logic [7:0] OFS_MAC_IRQ   = 8'h18;

	// mac control fields
	localparam int MC_SOFT_RST  = 0;
	localparam int MC_NEG_ALLOW = 1;
	localparam int MC_SPEED     = 2;
	localparam int MC_DUPLEX    = 3;
	// phy control fields
	localparam int PC_SELF_RST  = 15;
	localparam int PC_LOOPBACK  = 14;
	localparam int PC_SPEED     = 13;
	localparam int PC_NEG_EN    = 12;
	localparam int PC_POWER_OFF = 11;
	localparam int PC_ISOLATE   = 10;
	localparam int PC_RESTART   = 9;
	localparam int PC_DUPLEX    = 8;
	// phy configuration fields
	localparam int CF_LINK_DIS  = 0;
	localparam int CF_JAB_DIS   = 1;
	localparam int CF_APOL_DIS  = 2;
	// latched bit positions: status [3:0], status output uses same order
	localparam int LB_LINK      = 0;
	localparam int LB_JABBER    = 1;
	localparam int LB_REVPOL    = 2;
	localparam int LB_NEGDONE   = 3;
	// status output fields
	localparam int SO_IRQ       = 4;
	localparam int SO_SPEED     = 5;
	localparam int SO_DUPLEX    = 6;
	localparam int SO_READY     = 7;

	// reset values
	localparam logic       RST_NEG_ALLOW = 1'b0;
	localparam logic       RST_MAC_SPEED = 1'b1;
	localparam logic       RST_MAC_DUPLEX_SELECT  = 1'b0;
	localparam logic       RST_PHY_SPEED = 1'b1;
	localparam logic       RST_PHY_NEGEN = 1'b1;
	localparam logic       RST_PHY_DUPLEX_SELECT  = 1'b0;
	localparam logic [3:0] RST_MASK      = 4'h0;

	typedef logic [25:0] pmcr_cnt_t;

	typedef enum logic [1:0] {
		NEG_OFF,
		NEG_QUIET,
		NEG_LINKFAIL,
		NEG_DONE
	} pmcr_neg_t;

	// software-visible control bits
	typedef struct packed {
		logic softReset;
		logic macNegotiationAllow;
		logic macSpeed100;
		logic macDuplex;
		logic phySelfReset;
		logic loopback;
		logic phySpeed100;
		logic phyNegotiationEnable;
		logic phyPowerOff;
		logic phyIsolate;
		logic duplexSelect;
		logic linkDisable;
		logic jabberDisable;
		logic autopolarityDisable;
		logic [3:0] mask;
	} pmcr_ctl_t;

	// link-side inputs from the datapath and negotiation engine
	typedef struct packed {
		logic linkUp;
		logic negComplete;
		logic negSpeed100;
		logic negFullDuplex;
		logic rxActive;
		logic linkPulseOk;
		logic linkPulseWrong;
		logic soiWrong;
	} pmcr_link_t;
endpackage : pmcr_pkg

// ===== src/pmcr_phy_mode_control.sv
// Operation
// - negotiation runs only while mac allow and phy enable bits are both set
// - enabling negotiation silences transmit 1200-1500 ms, then link fail
// - mac allow clear takes speed and duplex from mac control bits
// - allow set, enable clear takes speed and duplex from phy control
// - done flag set only after a started negotiation completes
// - restart bit starts a fresh negotiation while negotiation runs; ignored otherwise
// - link disable forces link pass, control-bit speed/duplex, idle kept
// - at 10 Mbps a long transmit forces idle, half-duplex collision, jabber flags
// - jabber disable bit switches jabber detection off entirely
// - 3 bad link pulses or one bad idle pulse flag reversed polarity
// - reversed polarity corrected unless disabled; none at 100 Mbps
// - full duplex allows simultaneous traffic and never signals collision
// - with negotiation off, speed select forces 100 or 10 Mbps
// - loopback returns tx data and enable, disables line, halts pulses
// - powerdown floats outputs; exit clears off then isolate, ready 500 ms
// - latched bits catch changes, raise interrupt; read clears, refreshes
// - pending interrupt shows in mac summary and status output flag
// - pin high 100 ns or soft reset bit resets all; bit not self-clearing
// - after pin reset, a present enabled memory loads configuration
// - phy self reset bit self-clears, reads 1 until done, restores defaults
// - phy resets on pin or soft reset fall; ready 50 ms later
module pmcr_phy_mode_control
	import pmcr_pkg::*;
#(
	parameter int QUIET_CYCLES   = QUIET_CYC,
	parameter int PHY_RST_CYCLES = PHY_RST_CYC,
	parameter int PDN_CYCLES     = PDN_READY_CYC,
	parameter int JABBER_CYCLES  = JABBER_CYC
) (
	input  wire logic        clk,            // 40 MHz system clock
	input  wire logic        sys_rst,        // synchronous reset, high
	input  wire logic        hsel,           // ahb slave select
	input  wire logic [31:0] haddr,          // ahb address
	input  wire logic [1:0]  htrans,         // ahb transfer type
	input  wire logic        hwrite,         // ahb write
	input  wire logic [2:0]  hsize,          // ahb size, word only
	input  wire logic [31:0] hwdata,         // ahb write data
	input  wire logic        hready,         // ahb bus ready
	output logic      [31:0] hrdata,         // ahb read data
	output logic             hreadyout,      // ahb slave ready
	output logic             hresp,          // ahb response, okay
	input  wire logic        chipResetPin,   // external reset pin, high
	input  wire logic        eePresent,      // config memory fitted
	input  wire logic        eeEnable,       // config memory load enabled
	input  wire pmcr_link_t  linkIn,         // link-side status
	input  wire logic        miiTxEn,        // internal mii transmit enable
	input  wire logic [3:0]  miiTxd,         // internal mii transmit data
	output logic      [3:0]  loopRxd,        // looped receive data
	output logic             loopCrs,        // looped carrier sense
	output logic             loopActive,     // loopback path selected
	output logic             miiCol,         // collision to mac
	output logic             tpTxOn,         // line transmitter allowed
	output logic             tpRxOn,         // line receiver allowed
	output logic             linkPulseOn,    // link pulses / idle allowed
	output logic             tpOutEn_n,      // line driver enable, low on
	output logic             miiIsolated,    // mii outputs held idle
	output logic             polarityInvert, // invert receive polarity
	output logic             speed100,       // effective speed 100 Mbps
	output logic             fullDuplex,     // effective full duplex
	output logic             negRunning,     // negotiation engine enabled
	output logic             negKick,        // pulse: restart engine
	output logic             linkPass,       // link pass state
	output logic             phyReady,       // phy ready for operation
	output logic             phyInReset,     // phy circuits held in reset
	output logic             chipReset,      // chip-wide reset active
	output logic             eeLoadStart,    // pulse: load config memory
	output logic             macIrq          // mac interrupt summary
);

	typedef struct packed {
		pmcr_ctl_t   ctl;
		pmcr_neg_t   neg;
		pmcr_cnt_t   negCnt;
		pmcr_cnt_t   rstCnt;
		pmcr_cnt_t   pdnCnt;
		pmcr_cnt_t   jabCnt;
		logic [2:0]  pinCnt;
		logic        pinWasRst;
		logic        softWas;
		logic        negActWas;
		logic        negDone;
		logic        negSpd;
		logic        negDpx;
		logic        jabber;
		logic [1:0]  badPulses;
		logic        revPol;
		logic [3:0]  latched;
		logic [3:0]  pending;
		logic        dValid;
		logic [7:0]  dAddr;
		logic [31:0] hrdata;
		logic [3:0]  rxd;
		logic        crs;
		logic        lpbk;
		logic        col;
		logic        txOn;
		logic        rxOn;
		logic        pulseOn;
		logic        outEn_n;
		logic        isolated;
		logic        polInv;
		logic        spd;
		logic        dpx;
		logic        negRun;
		logic        kick;
		logic        linkOk;
		logic        ready;
		logic        phyRst;
		logic        chipRst;
		logic        eeLoad;
		logic        irq;
	} pmcr_state_t;

	pmcr_state_t s;
	pmcr_state_t next_s;

	////////////////////////////////////////////////////////////////////////
	// control register defaults, shared by the system reset and the chip reset
	function automatic pmcr_ctl_t ctlDefault(input logic keepSoft);
		pmcr_ctl_t c;
		c = '0;
		c.softReset            = keepSoft;
		c.macNegotiationAllow  = RST_NEG_ALLOW;
		c.macSpeed100          = RST_MAC_SPEED;
		c.macDuplex            = RST_MAC_DUPLEX_SELECT;
		c.phySpeed100          = RST_PHY_SPEED;
		c.phyNegotiationEnable = RST_PHY_NEGEN;
		c.duplexSelect         = RST_PHY_DUPLEX_SELECT;
		c.mask                 = RST_MASK;
		return c;
	endfunction : ctlDefault

	////////////////////////////////////////////////////////////////////////
	// all behaviour: bus slave, resets, negotiation, jabber, polarity
	always_comb begin
		logic       take;
		logic       negAct;
		logic       restart;
		logic       pinRst;
		logic       phyRstNow;
		logic       rdStat;
		logic       spdEff;
		logic       dpxEff;
		logic       linkEff;
		logic [3:0] cur;
		logic [3:0] chg;
		logic [31:0] rd;
		take      = 1'b0;
		negAct    = 1'b0;
		restart   = 1'b0;
		pinRst    = 1'b0;
		phyRstNow = 1'b0;
		rdStat    = 1'b0;
		spdEff    = 1'b0;
		dpxEff    = 1'b0;
		linkEff   = 1'b0;
		cur       = '0;
		chg       = '0;
		rd        = '0;
		next_s    = s;
		next_s.kick   = 1'b0;
		next_s.eeLoad = 1'b0;

		// pin must stay high the full qualifying time before it counts
		if (chipResetPin) begin
			if (s.pinCnt != 3'(PIN_RST_CYC))
				next_s.pinCnt = s.pinCnt + 3'h1;
		end else begin
			next_s.pinCnt = '0;
		end
		pinRst = chipResetPin && (s.pinCnt == 3'(PIN_RST_CYC));
		next_s.pinWasRst = pinRst;
		next_s.softWas   = s.ctl.softReset;

		// address phase capture; reads answer in the following data phase
		take = hsel && htrans[1] && hready;
		next_s.dValid = take && hwrite;
		next_s.dAddr  = haddr[7:0];
		if (take && !hwrite) begin
			unique case (haddr[7:0])
				OFS_MAC_CTRL: begin
					rd[MC_SOFT_RST]  = s.ctl.softReset;
					rd[MC_NEG_ALLOW] = s.ctl.macNegotiationAllow;
					rd[MC_SPEED]     = s.ctl.macSpeed100;
					rd[MC_DUPLEX]    = s.ctl.macDuplex;
				end
				OFS_PHY_CTRL: begin
					rd[PC_SELF_RST]  = s.phyRst;
					rd[PC_LOOPBACK]  = s.ctl.loopback;
					rd[PC_SPEED]     = s.ctl.phySpeed100;
					rd[PC_NEG_EN]    = s.ctl.phyNegotiationEnable;
					rd[PC_POWER_OFF] = s.ctl.phyPowerOff;
					rd[PC_ISOLATE]   = s.ctl.phyIsolate;
					rd[PC_DUPLEX]    = s.ctl.duplexSelect;
				end
				OFS_PHY_CFG: begin
					rd[CF_LINK_DIS] = s.ctl.linkDisable;
					rd[CF_JAB_DIS]  = s.ctl.jabberDisable;
					rd[CF_APOL_DIS] = s.ctl.autopolarityDisable;
				end
				OFS_PHY_STAT, OFS_PHY_SOUT: begin
					rd[3:0]       = s.latched;
					rd[SO_IRQ]    = s.irq;
					rd[SO_SPEED]  = s.spd;
					rd[SO_DUPLEX] = s.dpx;
					rd[SO_READY]  = s.ready;
					rdStat        = 1'b1;
				end
				OFS_PHY_MASK: rd[3:0] = s.ctl.mask;
				OFS_MAC_IRQ:  rd[0]   = s.irq;
				default:      rd      = '0;
			endcase
		end
		next_s.hrdata = rd;

		// data phase write of a whole word
		if (s.dValid) begin
			unique case (s.dAddr)
				OFS_MAC_CTRL: begin
					next_s.ctl.softReset           = hwdata[MC_SOFT_RST];
					next_s.ctl.macNegotiationAllow = hwdata[MC_NEG_ALLOW];
					next_s.ctl.macSpeed100         = hwdata[MC_SPEED];
					next_s.ctl.macDuplex           = hwdata[MC_DUPLEX];
				end
				OFS_PHY_CTRL: begin
					next_s.ctl.loopback    = hwdata[PC_LOOPBACK];
					next_s.ctl.phySpeed100 = hwdata[PC_SPEED];
					next_s.ctl.phyNegotiationEnable = hwdata[PC_NEG_EN];
					next_s.ctl.phyPowerOff = hwdata[PC_POWER_OFF];
					next_s.ctl.phyIsolate  = hwdata[PC_ISOLATE];
					next_s.ctl.duplexSelect = hwdata[PC_DUPLEX];
					restart = hwdata[PC_RESTART];
					// leaving powerdown lands in isolation, ready later
					if (s.ctl.phyPowerOff && !hwdata[PC_POWER_OFF]) begin
						next_s.ctl.phyIsolate = 1'b1;
						next_s.pdnCnt = pmcr_cnt_t'(PDN_CYCLES);
					end
					if (hwdata[PC_SELF_RST])
						phyRstNow = 1'b1;
				end
				OFS_PHY_CFG: begin
					next_s.ctl.linkDisable         = hwdata[CF_LINK_DIS];
					next_s.ctl.jabberDisable       = hwdata[CF_JAB_DIS];
					next_s.ctl.autopolarityDisable = hwdata[CF_APOL_DIS];
				end
				OFS_PHY_MASK: next_s.ctl.mask = hwdata[3:0];
				default: ;
			endcase
		end

		// phy reset: pin released after qualifying, or soft bit falls
		if (s.pinWasRst && !pinRst)
			phyRstNow = 1'b1;
		if (s.softWas && !s.ctl.softReset)
			phyRstNow = 1'b1;
		if (phyRstNow)
			next_s.rstCnt = pmcr_cnt_t'(PHY_RST_CYCLES);
		else if (s.rstCnt != '0)
			next_s.rstCnt = s.rstCnt - pmcr_cnt_t'(1);
		if (s.pdnCnt != '0)
			next_s.pdnCnt = s.pdnCnt - pmcr_cnt_t'(1);

		// config memory load follows a pin reset only
		next_s.eeLoad = s.pinWasRst && !pinRst && eePresent
		                && eeEnable;

		// negotiation engine control
		negAct = s.ctl.macNegotiationAllow
		         && s.ctl.phyNegotiationEnable;
		next_s.negActWas = negAct;
		if (!negAct) begin
			next_s.neg     = NEG_OFF;
			next_s.negDone = 1'b0;
		end else if ((negAct && !s.negActWas) || restart) begin
			next_s.neg     = NEG_QUIET;
			next_s.negCnt  = pmcr_cnt_t'(QUIET_CYCLES);
			next_s.negDone = 1'b0;
		end else begin
			unique case (s.neg)
				NEG_OFF: next_s.neg = NEG_OFF;
				NEG_QUIET: begin
					// all transmission held off through the quiet time
					if (s.negCnt <= pmcr_cnt_t'(1)) begin
						next_s.neg  = NEG_LINKFAIL;
						next_s.kick = 1'b1;
					end else begin
						next_s.negCnt = s.negCnt - pmcr_cnt_t'(1);
					end
				end
				NEG_LINKFAIL: begin
					if (linkIn.negComplete) begin
						next_s.neg     = NEG_DONE;
						next_s.negDone = 1'b1;
						next_s.negSpd  = linkIn.negSpeed100;
						next_s.negDpx  = linkIn.negFullDuplex;
					end
				end
				NEG_DONE: begin
					// losing the link starts a new negotiation
					if (!linkIn.linkUp && !s.ctl.linkDisable) begin
						next_s.neg     = NEG_LINKFAIL;
						next_s.negDone = 1'b0;
						next_s.kick    = 1'b1;
					end
				end
			endcase
		end

		// effective mode selection
		if (!s.ctl.macNegotiationAllow) begin
			spdEff = s.ctl.macSpeed100;
			dpxEff = s.ctl.macDuplex;
		end else if (!s.ctl.phyNegotiationEnable || s.ctl.linkDisable) begin
			spdEff = s.ctl.phySpeed100;
			dpxEff = s.ctl.duplexSelect;
		end else begin
			spdEff = s.negSpd;
			dpxEff = s.negDpx;
		end
		linkEff = s.ctl.linkDisable
		          || (linkIn.linkUp && (!negAct || s.neg == NEG_DONE));

		// jabber: 10 Mbps only and only when not disabled
		if (!spdEff && !s.ctl.jabberDisable && miiTxEn) begin
			if (s.jabCnt >= pmcr_cnt_t'(JABBER_CYCLES))
				next_s.jabber = 1'b1;
			else
				next_s.jabCnt = s.jabCnt + pmcr_cnt_t'(1);
		end else begin
			next_s.jabCnt = '0;
			next_s.jabber = 1'b0;
		end

		// polarity watch at 10 Mbps; a good pulse breaks the run
		if (spdEff) begin
			next_s.badPulses = '0;
			next_s.revPol    = 1'b0;
		end else if (linkIn.soiWrong) begin
			next_s.revPol = 1'b1;
		end else if (linkIn.linkPulseWrong) begin
			if (s.badPulses == 2'(POL_BAD_PULSES - 1))
				next_s.revPol = 1'b1;
			else
				next_s.badPulses = s.badPulses + 2'h1;
		end else if (linkIn.linkPulseOk) begin
			next_s.badPulses = '0;
		end

		// latch-on-change bits; a read reloads them from the current state and clears pending
		cur[LB_LINK]    = linkEff;
		cur[LB_JABBER]  = s.jabber;
		cur[LB_REVPOL]  = s.revPol;
		cur[LB_NEGDONE] = s.negDone;
		chg = cur ^ s.latched;
		for (int i = 0; i < 4; i++) begin
			if (rdStat) begin
				next_s.latched[i] = cur[i];
				next_s.pending[i] = 1'b0;
			end else if (!s.pending[i] && chg[i]) begin
				next_s.latched[i] = cur[i];
				next_s.pending[i] = 1'b1;
			end
		end
		next_s.irq = |(next_s.pending & ~s.ctl.mask);

		// line and mii outputs
		next_s.spd      = spdEff;
		next_s.dpx      = dpxEff;
		next_s.linkOk   = linkEff;
		next_s.negRun   = negAct;
		next_s.lpbk     = s.ctl.loopback;
		next_s.rxd      = s.ctl.loopback ? miiTxd : 4'h0;
		next_s.crs      = s.ctl.loopback && miiTxEn;
		next_s.col      = !dpxEff && !s.ctl.loopback
		                  && ((miiTxEn && linkIn.rxActive) || next_s.jabber);
		next_s.txOn     = !s.ctl.loopback && !s.ctl.phyPowerOff
		                  && !next_s.jabber && s.neg != NEG_QUIET;
		next_s.rxOn     = !s.ctl.loopback && !s.ctl.phyPowerOff;
		next_s.pulseOn  = next_s.txOn;
		next_s.outEn_n  = s.ctl.phyPowerOff;
		next_s.isolated = s.ctl.phyIsolate || s.ctl.phyPowerOff;
		next_s.polInv   = s.revPol && !spdEff
		                  && !s.ctl.autopolarityDisable;
		next_s.ready    = !s.phyRst && s.pdnCnt == '0 && !s.ctl.phyPowerOff;
		next_s.phyRst   = phyRstNow || s.rstCnt > pmcr_cnt_t'(1)
		                  || chipResetPin;
		next_s.chipRst  = pinRst || s.ctl.softReset;

		// chip reset restores control defaults and clears negotiation, latched, pending and polarity state; a soft reset keeps the soft bit itself, a pin reset clears it
		if (pinRst || s.ctl.softReset) begin
			// without a pin reset the written value of the soft bit survives, so software can end it
			next_s.ctl       = ctlDefault(next_s.ctl.softReset
			                              && !pinRst);
			next_s.neg       = NEG_OFF;
			next_s.negDone   = 1'b0;
			next_s.latched   = '0;
			next_s.pending   = '0;
			next_s.revPol    = 1'b0;
			next_s.badPulses = '0;
			next_s.pdnCnt    = '0;
		end else if (phyRstNow) begin
			// phy registers back to defaults, mac side untouched
			next_s.ctl.phySelfReset         = 1'b0;
			next_s.ctl.loopback             = 1'b0;
			next_s.ctl.phySpeed100          = RST_PHY_SPEED;
			next_s.ctl.phyNegotiationEnable = RST_PHY_NEGEN;
			next_s.ctl.phyPowerOff          = 1'b0;
			next_s.ctl.phyIsolate           = 1'b0;
			next_s.ctl.duplexSelect         = RST_PHY_DUPLEX_SELECT;
			next_s.ctl.linkDisable          = 1'b0;
			next_s.ctl.jabberDisable        = 1'b0;
			next_s.ctl.autopolarityDisable  = 1'b0;
			next_s.ctl.mask                 = RST_MASK;
			next_s.neg                      = NEG_OFF;
			next_s.negDone                  = 1'b0;
			next_s.pdnCnt                   = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s              <= '0;
			s.ctl          <= ctlDefault(1'b0);
			s.txOn         <= 1'b0;
			s.outEn_n      <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// every output but hreadyout and hresp is a field of the state register
	assign hrdata         = s.hrdata;
	assign hreadyout      = 1'b1;  // zero wait states, no stall path
	assign hresp          = 1'b0;
	assign loopRxd        = s.rxd;
	assign loopCrs        = s.crs;
	assign loopActive     = s.lpbk;
	assign miiCol         = s.col;
	assign tpTxOn         = s.txOn;
	assign tpRxOn         = s.rxOn;
	assign linkPulseOn    = s.pulseOn;
	assign tpOutEn_n      = s.outEn_n;
	assign miiIsolated    = s.isolated;
	assign polarityInvert = s.polInv;
	assign speed100       = s.spd;
	assign fullDuplex     = s.dpx;
	assign negRunning     = s.negRun;
	assign negKick        = s.kick;
	assign linkPass       = s.linkOk;
	assign phyReady       = s.ready;
	assign phyInReset     = s.phyRst;
	assign chipReset      = s.chipRst;
	assign eeLoadStart    = s.eeLoad;
	assign macIrq         = s.irq;

endmodule : pmcr_phy_mode_control

// ===== test/pmcr_phy_mode_control_monitor.sv
module pmcr_phy_mode_control_monitor
	import pmcr_pkg::*;
#(
	parameter int QUIET_CYCLES = 20 // quiet time, short run value
) (
	input wire logic       clk,            // clock
	input wire logic       sys_rst,        // reset
	input wire logic       chipResetPin,   // reset pin
	input wire logic       eePresent,      // memory fitted
	input wire logic       eeEnable,       // memory enabled
	input wire logic       miiTxEn,        // tx enable
	input wire logic [3:0] miiTxd,         // tx data
	input wire logic [3:0] loopRxd,        // looped data
	input wire logic       loopCrs,        // looped sense
	input wire logic       loopActive,     // loopback on
	input wire logic       miiCol,         // collision
	input wire logic       tpTxOn,         // line tx on
	input wire logic       tpRxOn,         // line rx on
	input wire logic       polarityInvert, // rx inverted
	input wire logic       speed100,       // 100 Mbps
	input wire logic       fullDuplex,     // full duplex
	input wire logic       negRunning,     // negotiating
	input wire logic       negKick,        // engine start
	input wire logic       phyReady,       // phy ready
	input wire logic       phyInReset,     // phy in reset
	input wire logic       chipReset,      // chip reset
	input wire logic       eeLoadStart     // memory load
);
	localparam int Q_LO = QUIET_CYCLES - 2;
	localparam int Q_HI = QUIET_CYCLES + 4;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////
	chk_pin_chip_reset: assert property (chipResetPin [*5] |=> chipReset)
		else $error("long pin pulse gave no chip reset");
	chk_pin_phy_reset: assert property (chipResetPin |=> phyInReset)
		else $error("phy not held in reset by pin");
	chk_phy_ready_wait: assert property ($fell(chipResetPin) |-> !phyReady [*8])
		else $error("phy ready too early after pin");
	chk_config_load: assert property (chipResetPin [*5] ##1
		(!chipResetPin && eePresent && eeEnable) |-> ##[0:2] eeLoadStart)
		else $error("config memory load not started");
	chk_fdx_no_col: assert property (fullDuplex && $past(fullDuplex) |-> !miiCol)
		else $error("collision in full duplex");
	chk_fast_no_pol: assert property (speed100 && $past(speed100) |-> !polarityInvert)
		else $error("polarity inverted at 100 Mbps");
	chk_loop_line_off: assert property (loopActive |-> !tpTxOn && !tpRxOn)
		else $error("line paths active in loopback");
	chk_loop_data: assert property (loopActive |->
		loopRxd == $past(miiTxd) && loopCrs == $past(miiTxEn))
		else $error("loopback data or sense wrong");
	chk_quiet_tx: assert property ($rose(negRunning) |-> ##2 !tpTxOn [*8])
		else $error("transmit not halted after enable");
	chk_quiet_kick: assert property ($rose(negRunning) |-> ##[Q_LO:Q_HI] negKick)
		else $error("negotiation not started after quiet");
endmodule : pmcr_phy_mode_control_monitor

bind pmcr_phy_mode_control pmcr_phy_mode_control_monitor #(
	.QUIET_CYCLES(QUIET_CYCLES)
) pmcr_phy_mode_control_monitor_i (.*);

// ===== test/pmcr_link_partner.sv
module pmcr_link_partner
	import pmcr_pkg::*;
#(
	parameter int REPLY_CYCLES = 6 // exchange length once kicked
) (
	input  wire logic       clk,       // system clock
	input  wire logic       sys_rst,   // reset, high
	input  wire logic       negKick,   // local engine restarted
	input  wire logic       tpTxOn,    // local transmitter on the line
	input  wire logic [1:0] advert,    // offered speed100, full duplex
	input  wire logic       badPulses, // send reversed link pulses
	output pmcr_link_t      linkOut    // what the line shows the block
);
	int cnt;

	// exchange counts down only while the local end transmits; the last step from 1 completes regardless
	always @(posedge clk) begin
		if (sys_rst) begin
			linkOut <= '0;
			cnt <= 0;
		end else begin
			linkOut.linkPulseWrong <= badPulses
			                          && !linkOut.linkPulseWrong;
			if (negKick) begin
				cnt <= REPLY_CYCLES;
				linkOut.negComplete <= 1'h0;
			end else if (cnt > 1 && tpTxOn) begin
				cnt <= cnt - 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				linkOut.linkUp <= 1'h1;
				linkOut.negComplete <= 1'h1;
				{linkOut.negSpeed100, linkOut.negFullDuplex} <= advert;
			end
		end
	end
endmodule : pmcr_link_partner

// ===== test/tb.sv
module tb
	import pmcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int QC = 20; // shortened quiet time
	localparam int RC = 10; // shortened reset and powerdown waits
	logic        clk = 1'h0, sys_rst = 1'h1, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0]  htrans = 2'h0, advert = 2'h3;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [3:0]  miiTxd = 4'h0, loopRxd;
	logic        chipResetPin = 1'h0, eePresent = 1'h1, eeEnable = 1'h1;
	logic        miiTxEn = 1'h0, badPulses = 1'h0, sawLoad = 1'h0;
	logic        hreadyout, hresp, loopCrs, loopActive, miiCol, tpTxOn;
	logic        tpRxOn, linkPulseOn, tpOutEn_n, miiIsolated, speed100;
	logic        polarityInvert, fullDuplex, negRunning, negKick, linkPass;
	logic        phyReady, phyInReset, chipReset, eeLoadStart, macIrq;
	pmcr_link_t  linkIn;
	int          n_errors = 0, compares = 0, cycles = 0;

	pmcr_phy_mode_control #(.QUIET_CYCLES(QC), .PHY_RST_CYCLES(RC),
		.PDN_CYCLES(RC), .JABBER_CYCLES(16)) pmcr_phy_mode_control_i (
		.hready(hreadyout), .*);
	pmcr_link_partner pmcr_link_partner_i (.linkOut(linkIn), .*);
	////////////////////////////////////////////////////////////////////////
	// clock, load pulse catcher and a cycle ceiling against hangs
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (eeLoadStart === 1'h1)
			sawLoad <= 1'h1;
		if (cycles == 2000) begin
			n_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// single word transfer; read data taken at the closing edge
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		{hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, wr, 24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'h1);
		{hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
		do @(posedge clk); while (hreadyout !== 1'h1);
		r = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'h1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
		ahb(1'h0, a, 32'h0, q);
		chk(q & m, e);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// main sequence: mode selection, negotiation, line faults, resets
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'h0;
		rd(OFS_PHY_CTRL, 32'h0000_FFFF, 32'h0000_3000);
		rd(8'h1C, 32'hFFFF_FFFF, 32'h0);
		wr(OFS_MAC_CTRL, 32'h0000_0008);
		tick(3);
		chk(32'({speed100, fullDuplex, negRunning}), 32'h2);
		wr(OFS_PHY_CTRL, 32'h0000_2000);
		wr(OFS_MAC_CTRL, 32'h0000_0002);
		tick(3);
		chk(32'({speed100, fullDuplex, negRunning}), 32'h4);
		wr(OFS_PHY_CTRL, 32'h0000_1000);
		tick(3);
		chk(32'({negRunning, tpTxOn}), 32'h2);
		tick(QC + 16);
		chk(32'({speed100, fullDuplex, tpTxOn, macIrq}), 32'hF);
		chk(32'({linkPass, linkPulseOn}), 32'h3);
		rd(OFS_MAC_IRQ, 32'h1, 32'h1);
		rd(OFS_PHY_SOUT, 32'h18, 32'h18);
		tick(2);
		chk(32'(macIrq), 32'h0);
		wr(OFS_PHY_CTRL, 32'h0000_1200);
		tick(3);
		chk(32'({tpTxOn, negRunning}), 32'h1);
		tick(QC + 16);
		wr(OFS_MAC_CTRL, 32'h0);
		{miiTxEn, badPulses} <= 2'h3;
		tick(24);
		chk(32'(polarityInvert), 32'h1);
		chk(32'({miiCol, tpTxOn}), 32'h2);
		wr(OFS_PHY_CFG, 32'h6);
		badPulses <= 1'h0;
		tick(3);
		chk(32'(miiCol), 32'h0);
		chk(32'(polarityInvert), 32'h0);
		wr(OFS_PHY_CTRL, 32'h0000_4000);
		miiTxd <= 4'hA;
		tick(3);
		chk(32'({loopRxd, loopCrs, tpTxOn, tpRxOn}), 32'h54);
		wr(OFS_PHY_CTRL, 32'h0000_0800);
		miiTxEn <= 1'h0;
		tick(3);
		chk(32'({tpOutEn_n, miiIsolated, tpRxOn}), 32'h6);
		wr(OFS_PHY_CTRL, 32'h0000_0400);
		wr(OFS_PHY_CTRL, 32'h0);
		tick(RC + 4);
		chk(32'({tpOutEn_n, miiIsolated, phyReady}), 32'h1);
		wr(OFS_MAC_CTRL, 32'h1);
		tick(3);
		chk(32'(chipReset), 32'h1);
		rd(OFS_MAC_CTRL, 32'h1, 32'h1);
		wr(OFS_MAC_CTRL, 32'h0);
		tick(3);
		chk(32'(phyReady), 32'h0);
		tick(RC + 4);
		chk(32'(phyReady), 32'h1);
		wr(OFS_PHY_CTRL, 32'h0000_8000);
		rd(OFS_PHY_CTRL, 32'h0000_8000, 32'h0000_8000);
		tick(RC + 4);
		rd(OFS_PHY_CTRL, 32'h0000_FFFF, 32'h0000_3000);
		chipResetPin <= 1'h1;
		tick(6);
		chk(32'({chipReset, phyInReset}), 32'h3);
		@(posedge clk);
		chipResetPin <= 1'h0;
		tick(4);
		chk(32'(sawLoad), 32'h1);
		tick(RC + 4);
		chk(32'(phyReady), 32'h1);
		test_done();
	end
endmodule : tb
